/* bfo_pkg.sv */
// bfo_pkg: constants and types for the bit and flag operation unit.
// assumes a single 32-bit AHB-Lite master and an 8-bit status layout chosen here.
package bfo_pkg;

  // register byte addresses
  localparam logic [7:0] BFO_ADDR_DATA   = 8'h00;
  localparam logic [7:0] BFO_ADDR_STATUS = 8'h04;
  localparam logic [7:0] BFO_ADDR_CMD    = 8'h08;
  localparam int         BFO_ADDR_LSB    = 0;
  localparam int         BFO_ADDR_MSB    = 7;

  // status register bit positions
  localparam int BFO_FLAG_C = 0;
  localparam int BFO_FLAG_Z = 1;
  localparam int BFO_FLAG_N = 2;
  localparam int BFO_FLAG_V = 3;
  localparam int BFO_FLAG_S = 4;
  localparam int BFO_FLAG_H = 5;
  localparam int BFO_FLAG_T = 6;
  localparam int BFO_FLAG_I = 7;

  // command word fields
  localparam int BFO_CMD_OP_LSB  = 0;
  localparam int BFO_CMD_OP_MSB  = 4;
  localparam int BFO_CMD_IDX_LSB = 8;
  localparam int BFO_CMD_IDX_MSB = 10;

  // reset values and the htrans NONSEQ mask
  localparam logic [7:0]  BFO_DATA_RST   = 8'h00;
  localparam logic [7:0]  BFO_STATUS_RST = 8'h00;
  localparam logic [31:0] BFO_WORD_ZERO  = 32'h0000_0000;
  localparam logic [1:0]  BFO_HTRANS_NONSEQ_BIT = 2'h2;

  typedef enum logic [4:0] {
    BFO_OP_NOP,
    BFO_OP_ROTATE_RIGHT_CARRY,
    BFO_OP_ARITH_SHIFT_RIGHT,
    BFO_OP_NIBBLE_SWAP,
    BFO_OP_STATUS_BIT_SET,
    BFO_OP_STATUS_BIT_CLEAR,
    BFO_OP_BIT_TO_TRANSFER_FLAG,
    BFO_OP_TRANSFER_FLAG_TO_BIT,
    BFO_OP_CARRY_SET,
    BFO_OP_CARRY_CLEAR,
    BFO_OP_NEGATIVE_SET,
    BFO_OP_NEGATIVE_CLEAR,
    BFO_OP_ZERO_SET,
    BFO_OP_ZERO_CLEAR,
    BFO_OP_IRQ_ENABLE,
    BFO_OP_IRQ_DISABLE,
    BFO_OP_SIGN_SET,
    BFO_OP_SIGN_CLEAR,
    BFO_OP_OVERFLOW_SET,
    BFO_OP_OVERFLOW_CLEAR
  } bfo_op_t;

  // a latched AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bfo_aphase_t;

  // a decoded command
  typedef struct packed {
    logic [2:0] idx;
    bfo_op_t    op;
  } bfo_cmd_t;

endpackage

/* bfo_unit.sv */
// bfo_unit: single-cycle bit, shift and status-flag operations behind an AHB-Lite slave.
// assumes one AHB-Lite master on core_clk_in; writing the command register executes it.
// Operation
// (RULE_01) rotate right through carry, update Z C N V
// (RULE_02) arithmetic shift right keeps sign, Z C N V
// (RULE_03) copy selected register bit into transfer flag
// (RULE_04) transfer flag into selected register bit only
// (RULE_05) set or clear zero flag only
// (RULE_06) set or clear global interrupt enable only
// (RULE_07) set or clear signed-test flag only
// (RULE_08) set or clear overflow flag only
// (RULE_09) carry, negative, indexed status bit set/clear
// (RULE_10) swap nibbles, flags unchanged
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module bfo_unit
  import bfo_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // results toward the core
  output logic      [7:0]  data_out,
  output logic      [7:0]  status_out
);

  function automatic logic [7:0] bfo_onehot(input logic [2:0] idx);
    bfo_onehot = 8'h01 << idx;
  endfunction

  bfo_aphase_t ph_q, ph_d;
  logic        rd_pend_q, rd_pend_d;
  logic [7:0]  data_q, data_d;
  logic [7:0]  status_q, status_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        hreadyout_q, hreadyout_d;
  logic        exec;
  bfo_cmd_t    cmd;
  logic [7:0]  res;
  logic [7:0]  st;

  assign cmd.op  = bfo_op_t'(hwdata_in[BFO_CMD_OP_MSB:BFO_CMD_OP_LSB]);
  assign cmd.idx = hwdata_in[BFO_CMD_IDX_MSB:BFO_CMD_IDX_LSB];
  assign exec    = ph_q.valid && ph_q.write && (ph_q.addr == BFO_ADDR_CMD);

  // operation datapath
  always_comb begin
    res = data_q;
    st  = status_q;
    case (cmd.op)
      BFO_OP_ROTATE_RIGHT_CARRY: begin
        res            = {status_q[BFO_FLAG_C], data_q[7:1]}; // RULE_01
        st[BFO_FLAG_C] = data_q[0];
        st[BFO_FLAG_N] = res[7];
        st[BFO_FLAG_Z] = (res == BFO_DATA_RST);
        st[BFO_FLAG_V] = res[7] ^ data_q[0];
      end
      BFO_OP_ARITH_SHIFT_RIGHT: begin
        res            = {data_q[7], data_q[7:1]}; // RULE_02
        st[BFO_FLAG_C] = data_q[0];
        st[BFO_FLAG_N] = res[7];
        st[BFO_FLAG_Z] = (res == BFO_DATA_RST);
        st[BFO_FLAG_V] = res[7] ^ data_q[0];
      end
      BFO_OP_NIBBLE_SWAP:          res = {data_q[3:0], data_q[7:4]}; // RULE_10
      BFO_OP_STATUS_BIT_SET:       st = status_q | bfo_onehot(cmd.idx); // RULE_09
      BFO_OP_STATUS_BIT_CLEAR:     st = status_q & ~bfo_onehot(cmd.idx); // RULE_09
      BFO_OP_BIT_TO_TRANSFER_FLAG: st[BFO_FLAG_T] = data_q[cmd.idx]; // RULE_03
      BFO_OP_TRANSFER_FLAG_TO_BIT: begin
        // RULE_04
        res = status_q[BFO_FLAG_T] ? (data_q | bfo_onehot(cmd.idx))
                                   : (data_q & ~bfo_onehot(cmd.idx));
      end
      BFO_OP_CARRY_SET:      st[BFO_FLAG_C] = 1'b1; // RULE_09
      BFO_OP_CARRY_CLEAR:    st[BFO_FLAG_C] = 1'b0; // RULE_09
      BFO_OP_NEGATIVE_SET:   st[BFO_FLAG_N] = 1'b1; // RULE_09
      BFO_OP_NEGATIVE_CLEAR: st[BFO_FLAG_N] = 1'b0; // RULE_09
      BFO_OP_ZERO_SET:       st[BFO_FLAG_Z] = 1'b1; // RULE_05
      BFO_OP_ZERO_CLEAR:     st[BFO_FLAG_Z] = 1'b0; // RULE_05
      BFO_OP_IRQ_ENABLE:     st[BFO_FLAG_I] = 1'b1; // RULE_06
      BFO_OP_IRQ_DISABLE:    st[BFO_FLAG_I] = 1'b0; // RULE_06
      BFO_OP_SIGN_SET:       st[BFO_FLAG_S] = 1'b1; // RULE_07
      BFO_OP_SIGN_CLEAR:     st[BFO_FLAG_S] = 1'b0; // RULE_07
      BFO_OP_OVERFLOW_SET:   st[BFO_FLAG_V] = 1'b1; // RULE_08
      BFO_OP_OVERFLOW_CLEAR: st[BFO_FLAG_V] = 1'b0; // RULE_08
      default: begin
        res = data_q;
        st  = status_q;
      end
    endcase
  end

  // bus slave: writes are zero-wait; reads take one wait state so that a read
  // right behind a write sees the written value
  always_comb begin
    ph_d        = ph_q;
    rd_pend_d   = 1'b0;
    data_d      = data_q;
    status_d    = status_q;
    hrdata_d    = hrdata_q;
    hreadyout_d = 1'b1;
    if (ph_q.valid && ph_q.write) begin
      case (ph_q.addr)
        BFO_ADDR_DATA:   data_d   = hwdata_in[7:0];
        BFO_ADDR_STATUS: status_d = hwdata_in[7:0];
        BFO_ADDR_CMD: begin
          data_d   = res;
          status_d = st;
        end
        default: data_d = data_q;
      endcase
    end
    if (rd_pend_q) begin
      case (ph_q.addr)
        BFO_ADDR_DATA:   hrdata_d = {24'h00_0000, data_q};
        BFO_ADDR_STATUS: hrdata_d = {24'h00_0000, status_q};
        default:         hrdata_d = BFO_WORD_ZERO;
      endcase
    end
    if (hready_in) begin
      ph_d.valid = hsel_in && ((htrans_in & BFO_HTRANS_NONSEQ_BIT) != 2'h0);
      ph_d.write = hwrite_in;
      ph_d.addr  = haddr_in[BFO_ADDR_MSB:BFO_ADDR_LSB];
      if (ph_d.valid && !hwrite_in) begin
        rd_pend_d   = 1'b1;
        hreadyout_d = 1'b0;
      end
    end else if (!rd_pend_q) begin
      ph_d.valid = ph_q.valid && !ph_q.write;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ph_q        <= '0;
      rd_pend_q   <= 1'b0;
      data_q      <= BFO_DATA_RST;
      status_q    <= BFO_STATUS_RST;
      hrdata_q    <= BFO_WORD_ZERO;
      hreadyout_q <= 1'b1;
    end else begin
      ph_q        <= ph_d;
      rd_pend_q   <= rd_pend_d;
      data_q      <= data_d;
      status_q    <= status_d;
      hrdata_q    <= hrdata_d;
      hreadyout_q <= hreadyout_d;
    end
  end

  assign hrdata_out    = hrdata_q;
  assign hreadyout_out = hreadyout_q;
  assign hresp_out     = 1'b0;
  assign data_out      = data_q;
  assign status_out    = status_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_exec(bfo_op_t o);
    exec && cmd.op == o;
  endsequence

  chk_ror_result: assert property ( // RULE_01
    s_exec(BFO_OP_ROTATE_RIGHT_CARRY) |=> data_q == {$past(status_q[BFO_FLAG_C]),
      $past(data_q[7:1])} && status_q[BFO_FLAG_C] == $past(data_q[0])
      && status_q[BFO_FLAG_V] == (data_q[7] ^ status_q[BFO_FLAG_C]))
    else $error("rotate right result or flags wrong");
  chk_asr_sign_kept: assert property ( // RULE_02
    s_exec(BFO_OP_ARITH_SHIFT_RIGHT) |=> data_q[7] == $past(data_q[7])
      && data_q[6:0] == $past(data_q[7:1]) && status_q[BFO_FLAG_Z] == (data_q == 8'h00))
    else $error("arithmetic shift wrong");
  chk_bst_transfer: assert property ( // RULE_03
    s_exec(BFO_OP_BIT_TO_TRANSFER_FLAG) |=> status_q[BFO_FLAG_T]
      == $past(data_q[cmd.idx]) && data_q == $past(data_q))
    else $error("bit store to transfer flag wrong");
  chk_bld_only_bit: assert property ( // RULE_04
    s_exec(BFO_OP_TRANSFER_FLAG_TO_BIT) |=> status_q == $past(status_q)
      && data_q[$past(cmd.idx)] == status_q[BFO_FLAG_T]
      && ((data_q ^ $past(data_q)) & ~bfo_onehot($past(cmd.idx))) == 8'h00)
    else $error("bit load touched other bits");
  chk_zero_force: assert property ( // RULE_05
    s_exec(BFO_OP_ZERO_SET) |=> status_q == ($past(status_q) | bfo_onehot(3'(BFO_FLAG_Z))))
    else $error("zero set wrong");
  chk_irq_clear: assert property ( // RULE_06
    s_exec(BFO_OP_IRQ_DISABLE) |=>
      status_q == ($past(status_q) & ~bfo_onehot(3'(BFO_FLAG_I))))
    else $error("interrupt disable wrong");
  chk_sign_set: assert property ( // RULE_07
    s_exec(BFO_OP_SIGN_SET) |=> status_q == ($past(status_q) | bfo_onehot(3'(BFO_FLAG_S))))
    else $error("sign set wrong");
  chk_ovf_clear: assert property ( // RULE_08
    s_exec(BFO_OP_OVERFLOW_CLEAR) |=>
      status_q == ($past(status_q) & ~bfo_onehot(3'(BFO_FLAG_V))))
    else $error("overflow clear wrong");
  chk_index_set: assert property ( // RULE_09
    s_exec(BFO_OP_STATUS_BIT_SET) |=> status_q[$past(cmd.idx)] && $stable(data_q))
    else $error("indexed set wrong");
  chk_swap_flags: assert property ( // RULE_10
    s_exec(BFO_OP_NIBBLE_SWAP) |=> $stable(status_q)
      && data_q == {$past(data_q[3:0]), $past(data_q[7:4])})
    else $error("nibble swap wrong");
  chk_read_wait: assert property (
    rd_pend_q |-> !hreadyout_q ##1 hreadyout_q)
    else $error("read wait state wrong");
  // writes must never stall: the command executes in the data phase cycle
  chk_write_nowait: assert property (
    hready_in && hsel_in && hwrite_in && (htrans_in & BFO_HTRANS_NONSEQ_BIT) != 2'h0
      |=> hreadyout_q)
    else $error("write data phase stalled");
  chk_zero_clear: assert property ( // RULE_05
    s_exec(BFO_OP_ZERO_CLEAR) |=> $stable(data_q)
      && status_q == ($past(status_q) & ~bfo_onehot(3'(BFO_FLAG_Z))))
    else $error("zero clear wrong");
  chk_irq_set: assert property ( // RULE_06
    s_exec(BFO_OP_IRQ_ENABLE) |=> $stable(data_q)
      && status_q == ($past(status_q) | bfo_onehot(3'(BFO_FLAG_I))))
    else $error("interrupt enable wrong");
  chk_sign_clear: assert property ( // RULE_07
    s_exec(BFO_OP_SIGN_CLEAR) |=> $stable(data_q)
      && status_q == ($past(status_q) & ~bfo_onehot(3'(BFO_FLAG_S))))
    else $error("sign clear wrong");
  chk_ovf_set: assert property ( // RULE_08
    s_exec(BFO_OP_OVERFLOW_SET) |=> $stable(data_q)
      && status_q == ($past(status_q) | bfo_onehot(3'(BFO_FLAG_V))))
    else $error("overflow set wrong");
  chk_carry_set: assert property ( // RULE_09
    s_exec(BFO_OP_CARRY_SET) |=> $stable(data_q)
      && status_q == ($past(status_q) | bfo_onehot(3'(BFO_FLAG_C))))
    else $error("carry set wrong");
  chk_neg_clear: assert property ( // RULE_09
    s_exec(BFO_OP_NEGATIVE_CLEAR) |=> $stable(data_q)
      && status_q == ($past(status_q) & ~bfo_onehot(3'(BFO_FLAG_N))))
    else $error("negative clear wrong");
  chk_index_clear: assert property ( // RULE_09
    s_exec(BFO_OP_STATUS_BIT_CLEAR) |=> !status_q[$past(cmd.idx)]
      && $stable(data_q))
    else $error("indexed clear wrong");

endmodule

/* bfo_host_model.sv */
// bfo_host_model: ahb-lite master in place of the decoder and register file.
// assumes the slave's hreadyout is the bus hready; single word transfers only.
`timescale 1ns/1ns
module bfo_host_model (
  // clock and bus answer
  input  wire logic        core_clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  // bus request
  output logic             hsel_out,
  output logic      [31:0] haddr_out,
  output logic      [1:0]  htrans_out,
  output logic             hwrite_out,
  output logic      [2:0]  hsize_out,
  output logic      [31:0] hwdata_out
);
  initial begin
    hsel_out   = 1'b0;
    haddr_out  = 32'h0000_0000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out  = 3'h2;
    hwdata_out = 32'h0000_0000;
  end
  task automatic wait_ready(inout logic ok);
    int n;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (hready_in !== 1'b1 && n < 20);
    if (hready_in !== 1'b1) ok = 1'b0;
  endtask
  // entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    ok = 1'b1;
    hsel_out   <= 1'b1;
    haddr_out  <= {24'h00_0000, a};
    htrans_out <= 2'h2;
    hwrite_out <= wr;
    // stale write data is inverted so early latching shows up
    hwdata_out <= ~hwdata_out;
    wait_ready(ok);
    hsel_out   <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= wd;
    wait_ready(ok);
    rd = hrdata_in;
  endtask
endmodule

/* bfo_unit_tb_top.sv */
// bfo_unit_tb_top: self-checking bench for the bit and flag operation unit.
// assumes the host model drives the bus and hreadyout closes the hready loop.
`timescale 1ns/1ns
module bfo_unit_tb_top;
  import bfo_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        hsel, hwrite, hrdy, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  data_q, status_q;
  int          fails   = 0;
  int          checked = 0;
  always #4 core_clk_in = ~core_clk_in;
  bfo_host_model HOST (.core_clk_in(core_clk_in), .hready_in(hrdy), .hrdata_in(hrdata),
    .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
    .hsize_out(hsize), .hwdata_out(hwdata));
  bfo_unit DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .data_out(data_q), .status_out(status_q));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic ok;
    HOST.xfer(wr, a, d, r, ok);
    chk("hresp", {31'h0, hresp}, BFO_WORD_ZERO);
    if (!ok) begin
      fails++;
      report_and_stop();
    end
  endtask
  function automatic logic [15:0] expect_op(input logic [4:0] op, input logic [2:0] ix,
                                            input logic [7:0] d, input logic [7:0] s);
    logic c;
    c = d[0];
    case (op)
      5'h01, 5'h02: begin
        d = {(op == 5'h01) ? s[BFO_FLAG_C] : d[7], d[7:1]};
        s[BFO_FLAG_C] = c;
        s[BFO_FLAG_Z] = (d == 8'h00);
        s[BFO_FLAG_N] = d[7];
        s[BFO_FLAG_V] = d[7] ^ c;
      end
      5'h03: d = {d[3:0], d[7:4]};
      5'h04: s[ix] = 1'b1;
      5'h05: s[ix] = 1'b0;
      5'h06: s[BFO_FLAG_T] = d[ix];
      5'h07: d[ix] = s[BFO_FLAG_T];
      5'h08, 5'h09: s[BFO_FLAG_C] = ~op[0];
      5'h0a, 5'h0b: s[BFO_FLAG_N] = ~op[0];
      5'h0c, 5'h0d: s[BFO_FLAG_Z] = ~op[0];
      5'h0e, 5'h0f: s[BFO_FLAG_I] = ~op[0];
      5'h10, 5'h11: s[BFO_FLAG_S] = ~op[0];
      5'h12, 5'h13: s[BFO_FLAG_V] = ~op[0];
      default: ;
    endcase
    return {s, d};
  endfunction
  // load operands, execute, then check the ports and the status and data read-backs
  task automatic run_op(input logic [4:0] op, input logic [2:0] ix, input logic [7:0] d,
                        input logic [7:0] s);
    logic [31:0] r;
    logic [15:0] e;
    e = expect_op(op, ix, d, s);
    bus(1'b1, BFO_ADDR_DATA, {24'h00_0000, d}, r);
    bus(1'b1, BFO_ADDR_STATUS, {24'h00_0000, s}, r);
    bus(1'b1, BFO_ADDR_CMD, {21'h00_0000, ix, 3'h0, op}, r);
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk("data_out", {24'h00_0000, data_q}, {24'h00_0000, e[7:0]});
    chk("status_out", {24'h00_0000, status_q}, {24'h00_0000, e[15:8]});
    @(posedge core_clk_in);
    bus(1'b0, BFO_ADDR_STATUS, 32'h0000_0000, r);
    chk("status read", r, {24'h00_0000, e[15:8]});
    bus(1'b0, BFO_ADDR_DATA, 32'h0000_0000, r);
    chk("data read", r, {24'h00_0000, e[7:0]});
  endtask
  task automatic t_reset();
    logic [31:0] r;
    chk("reset data", {24'h00_0000, data_q}, {24'h00_0000, BFO_DATA_RST});
    chk("reset status", {24'h00_0000, status_q}, {24'h00_0000, BFO_STATUS_RST});
    bus(1'b1, 8'h0c, 32'hffff_ffff, r);
    bus(1'b0, BFO_ADDR_CMD, 32'h0000_0000, r);
    chk("cmd read", r, BFO_WORD_ZERO);
    bus(1'b0, BFO_ADDR_DATA, 32'h0000_0000, r);
    chk("data read", r, BFO_WORD_ZERO);
  endtask
  task automatic t_shift();
    logic [7:0] dv [4] = '{8'h01, 8'h80, 8'hb6, 8'h00};
    for (int i = 0; i < 8; i++) begin
      run_op(5'h01, 3'h0, dv[i%4], (i < 4) ? 8'h00 : 8'hff);
      run_op(5'h02, 3'h0, dv[i%4], (i < 4) ? 8'h00 : 8'hff);
      run_op(5'h03, 3'h0, dv[i%4], (i < 4) ? 8'h00 : 8'hff);
    end
  endtask
  task automatic t_flags();
    for (int op = 8; op < 20; op++) begin
      run_op(op[4:0], 3'h0, 8'h5a, 8'h00);
      run_op(op[4:0], 3'h0, 8'h5a, 8'hff);
    end
  endtask
  task automatic t_index();
    for (int i = 0; i < 8; i++) begin
      run_op(5'h04, i[2:0], 8'h00, 8'h00);
      run_op(5'h05, i[2:0], 8'hff, 8'hff);
      run_op(5'h06, i[2:0], 8'ha5, 8'h00);
      run_op(5'h06, i[2:0], 8'ha5, 8'hff);
      run_op(5'h07, i[2:0], 8'h5a, 8'h40);
      run_op(5'h07, i[2:0], 8'ha5, 8'hbf);
    end
  endtask
  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    t_reset();
    t_shift();
    t_flags();
    t_index();
    report_and_stop();
  end
endmodule
